// ### design/rpp_consts.vh
`ifndef RPP_CONSTS_VH
`define RPP_CONSTS_VH
// Array geometry
`define RPP_ADDR_W 12
`define RPP_DATA_W 8
`define RPP_DEPTH 4096
// Architecture word encodings
`define RPP_ARCH_ASYNC_EN 2'h0
`define RPP_ARCH_SYNC_EN 2'h1
`define RPP_ARCH_ASYNC_INIT 2'h2
`define RPP_ARCH_SYNC_INIT 2'h3
// Reset values
`define RPP_DATA_RST 8'h00
`define RPP_INIT_WORD_RST 8'h00
`endif

// ### design/rpp_array.v
`timescale 1ns/1ps
`include "rpp_consts.vh"
// Fully decoded read-only array, combinational read
module rpp_array (
  // Read port
  input wire [`RPP_ADDR_W-1:0] addr,
  output wire [`RPP_DATA_W-1:0] word
);
  reg [`RPP_DATA_W-1:0] mem [0:`RPP_DEPTH-1];
  integer i;
  // Default contents: low byte of the address
  initial begin
    for (i = 0; i < `RPP_DEPTH; i = i + 1) begin
      mem[i] = i[`RPP_DATA_W-1:0];
    end
  end
  assign word = mem[addr];
endmodule

// ### design/rpp_top.v
`timescale 1ns/1ps
`include "rpp_consts.vh"
module rpp_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Programmed configuration
  input wire [1:0] arch_word,
  input wire [`RPP_DATA_W-1:0] init_word,
  // Address and control
  input wire [`RPP_ADDR_W-1:0] addr,
  input wire ctrl_n,
  // Data pins
  output reg [`RPP_DATA_W-1:0] data_out,
  output reg [`RPP_DATA_W-1:0] data_out_oe
);
  ////////////////////////////////////////////////////////////////////
  wire [`RPP_DATA_W-1:0] array_word;
  reg sync_en;
  reg [`RPP_DATA_W-1:0] next_pipe;
  reg next_sync_en;
  reg [`RPP_DATA_W-1:0] next_data_out;
  reg next_oe;
  wire ctrl_active;
  assign ctrl_active = ~ctrl_n;
  rpp_array u_array (
    .addr(addr),
    .word(array_word)
  );
  ////////////////////////////////////////////////////////////////////
  // Next register state
  always @* begin
    next_pipe = array_word;
    next_sync_en = sync_en;
    case (arch_word)
      `RPP_ARCH_ASYNC_EN: begin
        next_sync_en = 1'b0;
      end
      `RPP_ARCH_SYNC_EN: begin
        next_sync_en = ctrl_active;
      end
      `RPP_ARCH_ASYNC_INIT, `RPP_ARCH_SYNC_INIT: begin
        next_sync_en = 1'b0;
        if (ctrl_active) begin
          next_pipe = init_word;
        end
      end
      default: begin
        next_sync_en = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // Enable state register
  always @(posedge clk_sys) begin
    if (rst) begin
      sync_en <= 1'b0;
    end else begin
      sync_en <= next_sync_en;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Pin view, one cycle ahead so outputs come from flops
  always @* begin
    next_data_out = next_pipe;
    next_oe = 1'b1;
    case (arch_word)
      `RPP_ARCH_ASYNC_EN: begin
        next_oe = ctrl_active;
      end
      `RPP_ARCH_SYNC_EN: begin
        next_oe = next_sync_en;
      end
      // async initialize matches sync initialize: word shows after the next clk_sys edge
      `RPP_ARCH_ASYNC_INIT: begin
        next_oe = 1'b1;
      end
      `RPP_ARCH_SYNC_INIT: begin
        next_oe = 1'b1;
      end
      default: begin
        next_oe = 1'b1;
      end
    endcase
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      data_out <= `RPP_DATA_RST;
      data_out_oe <= {`RPP_DATA_W{1'b0}};
    end else begin
      data_out <= next_data_out;
      data_out_oe <= {`RPP_DATA_W{next_oe}};
    end
  end
endmodule

// ### sim/rpp_top_properties.sv
`timescale 1ns/1ps
module rpp_chk (input wire clk_sys, rst, ctrl_n, input wire [1:0] arch_word,
  input wire [7:0] init_word, data_out, data_out_oe, input wire [11:0] addr);
  wire [7:0] lo = addr[7:0];
  wire i = arch_word[1];
  wire e = !ctrl_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_array_word: assert property (!rst && !e |=> data_out == $past(lo))
    else $error("bad");
  a_init_load: assert property (!rst && e && i |=> data_out == $past(init_word))
    else $error("bad");
  a_enable_gate: assert property (!rst && !i |=> data_out_oe == {8{$past(e)}})
    else $error("bad");
  a_init_drive: assert property (!rst && i |=> &data_out_oe) else $error("bad");
  a_async_float: assert property (!rst && arch_word == 0 && !e |=> !data_out_oe)
    else $error("bad");
  a_low_enable: assert property (!rst && arch_word == 1 && e |=> &data_out_oe)
    else $error("bad");
  a_word_hold: assert property (!rst && !e ##1 !e && $stable(lo) |=> $stable(data_out))
    else $error("bad");
  a_reset_float: assert property (disable iff (0) rst |=> !(data_out | data_out_oe))
    else $error("bad");
endmodule
bind rpp_top rpp_chk i_chk (.clk_sys(clk_sys), .rst(rst), .ctrl_n(ctrl_n),
  .arch_word(arch_word), .init_word(init_word), .data_out(data_out),
  .data_out_oe(data_out_oe), .addr(addr));

// ### sim/rpp_seq.sv
`timescale 1ns/1ps
module rpp_seq (input wire clk_sys, next_ctrl_n, input wire [11:0] next_addr,
  output reg ctrl_n = 1, output reg [11:0] addr = 0);
  always @(posedge clk_sys) #1 {ctrl_n, addr} = {next_ctrl_n, next_addr};
endmodule

// ### sim/rpp_top_tb.sv
`timescale 1ns/1ps
module rpp_top_tb;
  reg clk_sys, rst, next_ctrl_n;
  reg [1:0] arch_word;
  reg [7:0] init_word;
  reg [11:0] next_addr;
  reg [15:0] exp;
  wire ctrl_n;
  wire [11:0] addr;
  wire [7:0] data_out, data_out_oe;
  integer n_errors, samples_checked, i;
  rpp_seq i_seq (.clk_sys(clk_sys), .next_ctrl_n(next_ctrl_n), .next_addr(next_addr),
    .ctrl_n(ctrl_n), .addr(addr));
  rpp_top i_dut (.clk_sys(clk_sys), .rst(rst), .arch_word(arch_word), .init_word(init_word),
    .addr(addr), .ctrl_n(ctrl_n), .data_out(data_out), .data_out_oe(data_out_oe));
  task chk(input [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %h %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("%0d errors %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {n_errors, samples_checked, exp, next_addr, arch_word, init_word} = 0;
    {rst, next_ctrl_n} = 2'h3;
    i = $urandom(32'hb270f76e);
    repeat (5) @(posedge clk_sys);
    for (i = 0; i < 1024; i++) begin
      #1 chk({data_out, data_out_oe});
      {rst, arch_word, init_word} = {i[7:0] == 8'h00, i[9:8], 8'($urandom)};
      exp = rst ? 16'h0000 : {arch_word[1] && !next_ctrl_n ? init_word : next_addr[7:0],
        arch_word[1] ? 8'hff : {8{!next_ctrl_n}}};
      @(posedge clk_sys);
      {next_ctrl_n, next_addr} <= i[4] ? 13'h1fff : $urandom;
    end
    #1 chk({data_out, data_out_oe});
    test_done;
  end
endmodule
